// >>> ccdr_pkg.sv
package ccdr_pkg;

  // Implementation register indices
  localparam logic [3:0] CCDR_IDX_CONFIG = 4'h0;
  localparam logic [3:0] CCDR_IDX_NC_OFFSET = 4'h3;
  localparam logic [3:0] CCDR_IDX_NC_BASES = 4'h4;
  localparam logic [3:0] CCDR_IDX_HALT_STATUS = 4'h7;
  localparam logic [3:0] CCDR_IDX_HALT_ADDR = 4'h8;
  localparam logic [3:0] CCDR_IDX_EMU_DATA = 4'h9;
  localparam logic [3:0] CCDR_IDX_EMU_TRAP = 4'hA;
  localparam logic [3:0] CCDR_IDX_POWER = 4'hB;
  localparam logic [3:0] CCDR_IDX_STANDBY_DIV = 4'hC;

  // Field positions, LSB-numbered
  localparam int CCDR_CFG_ICACHE = 31;
  localparam int CCDR_CFG_DCACHE = 30;
  localparam int CCDR_CFG_DCACHE_DUP = 29;
  localparam int CCDR_CFG_ENDIAN = 28;
  localparam int CCDR_CFG_BTB = 27;
  localparam int CCDR_CFG_FRACTION = 25;
  localparam int CCDR_CFG_FREEZE_LO = 20;
  localparam int CCDR_CFG_LO = 20;
  localparam int CCDR_NC_SYS_LO = 16;
  localparam int CCDR_NC_LEGACY = 20;
  localparam int CCDR_NC_R1_LO = 21;
  localparam int CCDR_NC_R2_LO = 24;
  localparam int CCDR_NC_WTHRU = 30;
  localparam int CCDR_PWR_SLEEP = 0;
  localparam int CCDR_PWR_DOZE = 1;
  localparam int CCDR_PWR_STANDBY = 2;

  // Reset values
  localparam logic [11:0] CCDR_RST_CONFIG = 12'h000;
  localparam logic [31:0] CCDR_RST_NC_OFFSET = 32'h0000_0000;
  localparam logic [31:0] CCDR_RST_NC_BASES = 32'h0000_0000;
  localparam logic [31:0] CCDR_RST_WORD = 32'h0000_0000;
  localparam logic [2:0] CCDR_RST_POWER = 3'h0;
  localparam logic [7:0] CCDR_RST_STANDBY_DIV = 8'h00;

  // Legacy hole and size encodings
  localparam logic [31:0] CCDR_LEGACY_LO = 32'h000A_0000;
  localparam logic [31:0] CCDR_LEGACY_HI = 32'h000F_FFFF;
  localparam logic [3:0] CCDR_SYS_MAX_CODE = 4'h9;
  localparam int CCDR_SYS_BASE_SHIFT = 19;
  localparam int CCDR_REGION_BASE_SHIFT = 15;
  localparam int CCDR_STANDBY_FACTOR = 4;

  typedef enum logic [1:0] {CCDR_OP_NONE, CCDR_OP_MOVE_TO, CCDR_OP_MOVE_FROM, CCDR_OP_EXIT}
    ccdr_op_t;

  typedef struct packed {
    ccdr_op_t op;
    logic [3:0] index;
    logic [31:0] wdata;
    logic [1:0] priv;
  } ccdr_req_t;

  typedef struct packed {
    logic [31:0] status_word;
    logic [31:0] front_address;
    logic [31:0] back_address;
  } ccdr_pipe_t;

endpackage

// >>> ccdr_registers.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Bits 31/30 enable caches; 29 mirrors 30 (here bit 29 is only stored, not tied to 30)
// - Bit 28 picks big or little endian
// - Bit 25 selects integer or fraction multiply
// - Bits 23..20 freeze instruction cache quarters
// - Offset bits 16-19 set system cacheable ceiling
// - Offset bit 20 uncaches 0xA0000-0xFFFFF
// - Offset bits 21-23 size region one
// - Offset bits 24-26 size region two
// - Region base aligned to its own size
// - Offset bit 30 selects write-through data cache
// - Base bits 0-15 region one, 16-31 two
// - Halt saves status word and address pair
// - Emulator data word exchanges thirty-two bits
// - Selected trap events force halt state
// - Power bits select sleep, doze, stand-by
// - Stand-by clock divides by four times (n+1)
// - Exit restores status and addresses, leaves halt
// - Exit runs at any privilege level
// - Move-to writes low n bits of register; config takes bits 31..20
// - Move-from returns low n bits zero-extended; config returns bits 31..20
// - Move to a defined index at nonzero privilege raises trap
module ccdr_registers
  import ccdr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction requests from the pipeline
  input wire ccdr_req_t req,
  output ccdr_req_t unused_req_echo_n,
  // Pipeline state and events
  input wire logic halt_enter,
  input wire ccdr_pipe_t pipe_state,
  input wire logic [31:0] trap_events,
  input wire logic [31:0] probe_address,
  // Results
  output logic [31:0] move_result,
  output logic move_result_valid,
  output logic priv_trap,
  output logic halt_request,
  output logic exit_restore,
  output ccdr_pipe_t restore_state,
  // Configuration to the core
  output logic icache_enable,
  output logic dcache_enable,
  output logic little_endian,
  output logic btb_enable,
  output logic fraction_mode,
  output logic [3:0] icache_freeze,
  output logic write_through,
  output logic probe_noncacheable,
  output logic sleep_mode,
  output logic doze_mode,
  output logic standby_mode,
  output logic standby_core_clock
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_move;
  logic priv_ok;
  logic index_known;
  logic do_write;
  logic [31:0] read_word;
  logic [31:0] trap_hit;

  logic [11:0] core_configuration;
  logic [31:0] noncacheable_offset_config;
  logic [31:0] noncacheable_region_bases;
  logic [31:0] halt_status_backup;
  logic [31:0] halt_address_queue_backup;
  logic [31:0] emulator_data_exchange;
  logic [31:0] emulator_trap_select;
  logic [2:0] power_mode_control;
  logic [7:0] standby_clock_divider;

  assign is_move = (req.op == CCDR_OP_MOVE_TO) || (req.op == CCDR_OP_MOVE_FROM);
  assign priv_ok = (req.priv == 2'h0);
  assign index_known = (req.index == CCDR_IDX_CONFIG) || (req.index == CCDR_IDX_NC_OFFSET)
    || (req.index == CCDR_IDX_NC_BASES) || ((req.index >= CCDR_IDX_HALT_STATUS)
    && (req.index <= CCDR_IDX_STANDBY_DIV));
  assign do_write = (req.op == CCDR_OP_MOVE_TO) && priv_ok && index_known;
  assign trap_hit = trap_events & emulator_trap_select;

  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (req.index)
      CCDR_IDX_CONFIG: read_word = {core_configuration, 20'h00000};
      CCDR_IDX_NC_OFFSET: read_word = noncacheable_offset_config;
      CCDR_IDX_NC_BASES: read_word = noncacheable_region_bases;
      CCDR_IDX_HALT_STATUS: read_word = halt_status_backup;
      CCDR_IDX_HALT_ADDR: read_word = halt_address_queue_backup;
      CCDR_IDX_EMU_DATA: read_word = emulator_data_exchange;
      CCDR_IDX_EMU_TRAP: read_word = emulator_trap_select;
      CCDR_IDX_POWER: read_word = {29'h0, power_mode_control};
      CCDR_IDX_STANDBY_DIV: read_word = {24'h000000, standby_clock_divider};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      core_configuration <= CCDR_RST_CONFIG;
      noncacheable_offset_config <= CCDR_RST_NC_OFFSET;
      noncacheable_region_bases <= CCDR_RST_NC_BASES;
      emulator_data_exchange <= CCDR_RST_WORD;
      emulator_trap_select <= CCDR_RST_WORD;
      power_mode_control <= CCDR_RST_POWER;
      standby_clock_divider <= CCDR_RST_STANDBY_DIV;
    end
    else if (do_write)
    begin
      unique case (req.index)
        CCDR_IDX_CONFIG: core_configuration <= req.wdata[31:CCDR_CFG_LO];
        CCDR_IDX_NC_OFFSET: noncacheable_offset_config <= req.wdata;
        CCDR_IDX_NC_BASES: noncacheable_region_bases <= req.wdata;
        CCDR_IDX_EMU_DATA: emulator_data_exchange <= req.wdata;
        CCDR_IDX_EMU_TRAP: emulator_trap_select <= req.wdata;
        CCDR_IDX_POWER: power_mode_control <= req.wdata[2:0];
        CCDR_IDX_STANDBY_DIV: standby_clock_divider <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Halt backups: halt entry wins over a software write
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      halt_status_backup <= CCDR_RST_WORD;
      halt_address_queue_backup <= CCDR_RST_WORD;
    end
    else if (halt_enter)
    begin
      halt_status_backup <= pipe_state.status_word;
      halt_address_queue_backup <= {pipe_state.front_address[31:16],
        pipe_state.back_address[31:16]};
    end
    else if (do_write && (req.index == CCDR_IDX_HALT_STATUS))
      halt_status_backup <= req.wdata;
    else if (do_write && (req.index == CCDR_IDX_HALT_ADDR))
      halt_address_queue_backup <= req.wdata;
  end

  // ----------------------------------------------------------------
  // Instruction results
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      move_result <= 32'h0000_0000;
      move_result_valid <= 1'b0;
      priv_trap <= 1'b0;
      halt_request <= 1'b0;
      exit_restore <= 1'b0;
      restore_state <= '0;
      unused_req_echo_n <= '0;
    end
    else
    begin
      unused_req_echo_n <= '0;
      priv_trap <= is_move && index_known && !priv_ok;
      move_result_valid <= (req.op == CCDR_OP_MOVE_FROM) && priv_ok && index_known;
      move_result <= ((req.op == CCDR_OP_MOVE_FROM) && priv_ok && index_known)
        ? read_word : move_result;
      halt_request <= |trap_hit;
      exit_restore <= (req.op == CCDR_OP_EXIT);
      restore_state.status_word <= halt_status_backup;
      restore_state.front_address <= {halt_address_queue_backup[31:16], 16'h0000};
      restore_state.back_address <= {halt_address_queue_backup[15:0], 16'h0000};
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic [3:0] sys_code;
  logic [2:0] r1_code;
  logic [2:0] r2_code;
  logic sys_hit;
  logic r1_hit;
  logic r2_hit;
  logic legacy_hit;
  logic [31:0] sys_limit;

  function automatic logic region_match(input logic [2:0] code, input logic [15:0] base,
    input logic [31:0] addr);
    logic [31:0] mask;
    logic [31:0] start;
    mask = 32'hFFFF_FFFF << (CCDR_REGION_BASE_SHIFT + 32'(code));
    start = {base, 16'h0000} & mask;
    region_match = (code != 3'h0) && ((addr & mask) == start);
  endfunction

  assign sys_code = noncacheable_offset_config[CCDR_NC_SYS_LO +: 4];
  assign r1_code = noncacheable_offset_config[CCDR_NC_R1_LO +: 3];
  assign r2_code = noncacheable_offset_config[CCDR_NC_R2_LO +: 3];
  assign sys_limit = 32'h0000_0001 << (CCDR_SYS_BASE_SHIFT + 32'(sys_code));
  assign sys_hit = (sys_code != 4'h0) && (sys_code <= CCDR_SYS_MAX_CODE)
    && (probe_address >= sys_limit);
  assign legacy_hit = noncacheable_offset_config[CCDR_NC_LEGACY]
    && (probe_address >= CCDR_LEGACY_LO) && (probe_address <= CCDR_LEGACY_HI);
  assign r1_hit = region_match(r1_code, noncacheable_region_bases[15:0], probe_address);
  assign r2_hit = region_match(r2_code, noncacheable_region_bases[31:16],
    probe_address);

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      icache_enable <= 1'b0;
      dcache_enable <= 1'b0;
      little_endian <= 1'b0;
      btb_enable <= 1'b0;
      fraction_mode <= 1'b0;
      icache_freeze <= 4'h0;
      write_through <= 1'b0;
      probe_noncacheable <= 1'b0;
      sleep_mode <= 1'b0;
      doze_mode <= 1'b0;
      standby_mode <= 1'b0;
    end
    else
    begin
      icache_enable <= core_configuration[CCDR_CFG_ICACHE - CCDR_CFG_LO];
      dcache_enable <= core_configuration[CCDR_CFG_DCACHE - CCDR_CFG_LO];
      little_endian <= core_configuration[CCDR_CFG_ENDIAN - CCDR_CFG_LO];
      btb_enable <= core_configuration[CCDR_CFG_BTB - CCDR_CFG_LO];
      fraction_mode <= core_configuration[CCDR_CFG_FRACTION - CCDR_CFG_LO];
      // Quarter 0 follows bit 23, quarter 3 bit 20
      icache_freeze <= {core_configuration[0], core_configuration[1],
        core_configuration[2], core_configuration[3]};
      write_through <= noncacheable_offset_config[CCDR_NC_WTHRU];
      probe_noncacheable <= sys_hit || legacy_hit || r1_hit || r2_hit;
      sleep_mode <= power_mode_control[CCDR_PWR_SLEEP];
      doze_mode <= power_mode_control[CCDR_PWR_DOZE];
      standby_mode <= power_mode_control[CCDR_PWR_STANDBY];
    end
  end

  // ----------------------------------------------------------------
  // Stand-by clock divider
  // ----------------------------------------------------------------
  logic [9:0] div_count;
  logic [9:0] half_period;

  // Toggle every 2*(n+1) cycles gives period 4*(n+1)
  assign half_period = 10'((CCDR_STANDBY_FACTOR / 2) * (32'(standby_clock_divider) + 1));

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      div_count <= 10'h000;
      standby_core_clock <= 1'b0;
    end
    else if (!power_mode_control[CCDR_PWR_STANDBY])
    begin
      div_count <= 10'h000;
      standby_core_clock <= 1'b0;
    end
    else if (div_count >= half_period - 10'h001)
    begin
      div_count <= 10'h000;
      standby_core_clock <= ~standby_core_clock;
    end
    else
      div_count <= div_count + 10'h001;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wr_config;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (do_write && req.index == CCDR_IDX_CONFIG) |-> ##2 icache_enable == $past(req.wdata[31], 2);
  endproperty
  a_wr_config: assert property (p_wr_config) else $error("icache enable mismatch");

  property p_priv;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (is_move && index_known && req.priv != 2'h0) |=> priv_trap && !move_result_valid;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege trap missing");

  property p_exit_any;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (req.op == CCDR_OP_EXIT) |=> exit_restore && !priv_trap;
  endproperty
  a_exit_any: assert property (p_exit_any) else $error("exit not honoured");

  property p_halt_save;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    halt_enter |=> halt_status_backup == $past(pipe_state.status_word);
  endproperty
  a_halt_save: assert property (p_halt_save) else $error("status not saved");

  property p_trap;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (|(trap_events & emulator_trap_select)) |=> halt_request;
  endproperty
  a_trap: assert property (p_trap) else $error("trap halt missing");

  property p_undefined;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (is_move && !index_known) |=> !priv_trap && !move_result_valid
      && $stable(emulator_data_exchange);
  endproperty
  a_undefined: assert property (p_undefined) else $error("undefined index acted");

  property p_readback;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (req.op == CCDR_OP_MOVE_FROM && priv_ok && req.index == CCDR_IDX_POWER)
      |=> move_result == {29'h0, power_mode_control};
  endproperty
  a_readback: assert property (p_readback) else $error("power readback wrong");

  property p_standby_off;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    !power_mode_control[CCDR_PWR_STANDBY] |=> !standby_core_clock;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("clock runs idle");

  property p_wr_block;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (req.op == CCDR_OP_MOVE_TO && index_known && !priv_ok)
      |=> $stable(emulator_data_exchange) && $stable(power_mode_control);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("trapped write landed");

  property p_power_modes;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (do_write && req.index == CCDR_IDX_POWER)
      |-> ##2 {standby_mode, doze_mode, sleep_mode} == $past(req.wdata[2:0], 2);
  endproperty
  a_power_modes: assert property (p_power_modes) else $error("power mode mismatch");

  c_move_to: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) do_write);
  c_move_from: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) move_result_valid);
  c_exit: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) exit_restore);
  c_standby: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $rose(standby_core_clock));

endmodule

// >>> ccdr_registers_test.sv
`timescale 1ns/10ps
module ccdr_registers_test
  import ccdr_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  logic halt_enter;
  ccdr_req_t req;
  ccdr_pipe_t pipe_state;
  ccdr_pipe_t restore_state;
  logic [31:0] trap_events;
  logic [31:0] probe_address;
  logic [31:0] move_result;
  logic move_result_valid, priv_trap, halt_request, exit_restore;
  logic icache_enable, dcache_enable, little_endian, btb_enable, fraction_mode;
  logic [3:0] icache_freeze;
  logic write_through, probe_noncacheable, sleep_mode, doze_mode, standby_mode;
  logic standby_core_clock;
  ccdr_req_t req_echo;
  int n_mismatch;
  int samples_checked;
  localparam logic [3:0] BAD_IDX [6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hD, 4'hF};
  localparam logic [31:0] CFG_PAT [2] = '{32'hE2A0_0000, 32'h1850_0000};

  ccdr_registers dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .unused_req_echo_n(req_echo),
    .halt_enter(halt_enter), .pipe_state(pipe_state), .trap_events(trap_events),
    .probe_address(probe_address), .move_result(move_result),
    .move_result_valid(move_result_valid), .priv_trap(priv_trap),
    .halt_request(halt_request), .exit_restore(exit_restore), .restore_state(restore_state),
    .icache_enable(icache_enable), .dcache_enable(dcache_enable),
    .little_endian(little_endian), .btb_enable(btb_enable), .fraction_mode(fraction_mode),
    .icache_freeze(icache_freeze), .write_through(write_through),
    .probe_noncacheable(probe_noncacheable), .sleep_mode(sleep_mode),
    .doze_mode(doze_mode), .standby_mode(standby_mode),
    .standby_core_clock(standby_core_clock));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      n_mismatch++;
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    check(name, {31'h0, e}, {31'h0, g});
  endtask

  // Returns just after the answering edge, while result pulses stand
  task automatic op_run(input ccdr_op_t op, input logic [3:0] idx, input logic [31:0] wd,
    input logic [1:0] pr);
    @(posedge ref_clk);
    req <= '{op: op, index: idx, wdata: wd, priv: pr};
    @(posedge ref_clk);
    req.op <= CCDR_OP_NONE;
    #1;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    op_run(CCDR_OP_MOVE_TO, idx, wd, 2'h0);
    chk1("write_trap", 1'b0, priv_trap);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] e);
    op_run(CCDR_OP_MOVE_FROM, idx, 32'h0, 2'h0);
    chk1("read_valid", 1'b1, move_result_valid);
    check("read_data", e, move_result);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic nc(input logic [31:0] off, input logic [31:0] a, input logic e);
    wr(CCDR_IDX_NC_OFFSET, off);
    @(posedge ref_clk);
    probe_address <= a;
    settle(3);
    chk1("probe_noncacheable", e, probe_noncacheable);
    chk1("write_through", off[30], write_through);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  initial
  begin
    repeat (6000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin : main_seq
    int t0;
    int t1;
    logic prev;
    logic seen;
    rst_n = 1'b0;
    halt_enter = 1'b0;
    req = '{op: CCDR_OP_NONE, index: 4'h0, wdata: 32'h0, priv: 2'h0};
    pipe_state = '0;
    trap_events = 32'h0;
    probe_address = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(2);
    check("reset_outputs", 32'h0, {13'h0, icache_enable, dcache_enable, little_endian,
      btb_enable, fraction_mode, icache_freeze, write_through, sleep_mode, doze_mode,
      standby_mode, halt_request, standby_core_clock, probe_noncacheable, priv_trap,
      move_result_valid, exit_restore});
    rd(CCDR_IDX_CONFIG, 32'h0);
    rd(CCDR_IDX_NC_OFFSET, 32'h0);
    rd(CCDR_IDX_NC_BASES, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(CCDR_IDX_CONFIG, CFG_PAT[i] | 32'h000F_FFFF);
      settle(1);
      check("config_outputs", {23'h0, CFG_PAT[i][31], CFG_PAT[i][30], CFG_PAT[i][28],
        CFG_PAT[i][27], CFG_PAT[i][25], CFG_PAT[i][20], CFG_PAT[i][21], CFG_PAT[i][22],
        CFG_PAT[i][23]}, {23'h0, icache_enable, dcache_enable, little_endian, btb_enable,
        fraction_mode, icache_freeze});
      rd(CCDR_IDX_CONFIG, CFG_PAT[i]);
    end
    wr(CCDR_IDX_NC_BASES, 32'h0040_0013);
    rd(CCDR_IDX_NC_BASES, 32'h0040_0013);
    nc(32'h0000_0000, 32'h0012_0000, 1'b0);
    nc(32'h0001_0000, 32'h0020_0000, 1'b1);
    nc(32'h0001_0000, 32'h0008_0000, 1'b0);
    nc(32'h0009_0000, 32'h2000_0000, 1'b1);
    nc(32'h0009_0000, 32'h0800_0000, 1'b0);
    nc(32'h0010_0000, 32'h000A_0000, 1'b1);
    nc(32'h0010_0000, 32'h000F_FFFF, 1'b1);
    nc(32'h0010_0000, 32'h0009_FFFF, 1'b0);
    nc(32'h0000_0000, 32'h000A_0000, 1'b0);
    nc(32'h0040_0000, 32'h0012_0000, 1'b1);
    nc(32'h0040_0000, 32'h0014_0000, 1'b0);
    nc(32'h0100_0000, 32'h0040_1000, 1'b1);
    nc(32'h4100_0000, 32'h0041_0000, 1'b0);
    rd(CCDR_IDX_NC_OFFSET, 32'h4100_0000);
    for (logic [3:0] x = CCDR_IDX_HALT_STATUS; x <= CCDR_IDX_EMU_TRAP; x++)
    begin
      wr(x, 32'hC3C3_5A50 | {28'h0, x});
      rd(x, 32'hC3C3_5A50 | {28'h0, x});
    end
    wr(CCDR_IDX_EMU_TRAP, 32'h0000_0100);
    @(posedge ref_clk);
    trap_events <= 32'h0000_0080;
    settle(2);
    chk1("halt_request", 1'b0, halt_request);
    @(posedge ref_clk);
    trap_events <= 32'h0000_0100;
    settle(2);
    chk1("halt_request", 1'b1, halt_request);
    @(posedge ref_clk);
    trap_events <= 32'h0;
    pipe_state <= '{status_word: 32'h1234_8765, front_address: 32'hA5A5_0004,
      back_address: 32'h5A5A_0008};
    halt_enter <= 1'b1;
    @(posedge ref_clk);
    halt_enter <= 1'b0;
    rd(CCDR_IDX_HALT_STATUS, 32'h1234_8765);
    chk1("halt_release", 1'b0, halt_request);
    rd(CCDR_IDX_HALT_ADDR, 32'hA5A5_5A5A);
    op_run(CCDR_OP_EXIT, 4'h0, 32'h0, 2'h3);
    chk1("exit_restore", 1'b1, exit_restore);
    chk1("exit_trap", 1'b0, priv_trap);
    check("restore_status", 32'h1234_8765, restore_state.status_word);
    check("restore_front", 32'hA5A5, {16'h0, restore_state.front_address[31:16]});
    check("restore_back", 32'h5A5A, {16'h0, restore_state.back_address[31:16]});
    for (int i = 0; i < 3; i++)
    begin
      wr(CCDR_IDX_POWER, 32'hFFFF_FFF8 | (32'h1 << i));
      settle(1);
      check("power_modes", 32'h1 << i, {29'h0, standby_mode, doze_mode, sleep_mode});
      rd(CCDR_IDX_POWER, 32'h1 << i);
    end
    wr(CCDR_IDX_STANDBY_DIV, 32'hFFFF_FF02);
    rd(CCDR_IDX_STANDBY_DIV, 32'h0000_0002);
    t0 = -1;
    t1 = -1;
    prev = standby_core_clock;
    for (int i = 0; i < 60; i++)
    begin
      settle(1);
      if (prev === 1'b0 && standby_core_clock === 1'b1)
      begin
        if (t0 < 0)
          t0 = i;
        else if (t1 < 0)
          t1 = i;
      end
      prev = standby_core_clock;
    end
    check("standby_period", CCDR_STANDBY_FACTOR * 3, 32'(t1 - t0));
    wr(CCDR_IDX_POWER, 32'h0);
    settle(4);
    seen = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      settle(1);
      seen = seen | standby_core_clock;
    end
    chk1("standby_clock_idle", 1'b0, seen);
    wr(CCDR_IDX_EMU_DATA, 32'h0F0F_1234);
    for (int p = 1; p < 4; p++)
    begin
      op_run(CCDR_OP_MOVE_TO, CCDR_IDX_EMU_DATA, 32'hFFFF_0000, 2'(p));
      chk1("priv_trap_to", 1'b1, priv_trap);
      op_run(CCDR_OP_MOVE_FROM, CCDR_IDX_EMU_DATA, 32'h0, 2'(p));
      chk1("priv_trap_from", 1'b1, priv_trap);
      chk1("priv_no_valid", 1'b0, move_result_valid);
    end
    rd(CCDR_IDX_EMU_DATA, 32'h0F0F_1234);
    for (int i = 0; i < 6; i++)
    begin
      op_run(CCDR_OP_MOVE_TO, BAD_IDX[i], 32'hFFFF_FFFF, 2'h1);
      chk1("bad_idx_trap", 1'b0, priv_trap);
      op_run(CCDR_OP_MOVE_FROM, BAD_IDX[i], 32'h0, 2'h0);
      chk1("bad_idx_valid", 1'b0, move_result_valid);
    end
    rd(CCDR_IDX_CONFIG, CFG_PAT[1]);
    rd(CCDR_IDX_EMU_DATA, 32'h0F0F_1234);
    chk1("req_echo_zero", 1'b0, |req_echo);
    // Mid-run reset returns registers to defaults
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(2);
    chk1("reset_endian", 1'b0, little_endian);
    rd(CCDR_IDX_CONFIG, 32'h0);
    rd(CCDR_IDX_EMU_DATA, 32'h0);
    results();
  end
endmodule
